// ### design/dsa_source_active.sv
`timescale 1ns/10ps
module dsa_source_active
#(
    parameter int SETS = dsa_pkg::DST_SETS
)
(
    // clock, reset and enable
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // avalon-mm register slave
    input wire logic [dsa_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [dsa_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [dsa_pkg::DATA_W-1:0] avs_readdata_out,
    output logic [1:0] avs_response_out,
    output logic avs_waitrequest_out,
    // transfer request from the channel controller
    input wire logic tr_load_in,
    input wire logic [31:0] tr_options_in,
    input wire logic [31:0] tr_src_addr_in,
    input wire logic [31:0] tr_dst_addr_in,
    // read and write progress
    input wire logic read_done_in,
    input wire logic [dsa_pkg::STEP_W-1:0] read_bytes_in,
    input wire logic write_done_in,
    input wire logic [dsa_pkg::STEP_W-1:0] write_bytes_in,
    // destination fifo hand-off and retirement
    input wire logic dst_push_in,
    input wire logic dst_pop_in,
    // live state
    output logic [31:0] active_options_out,
    output logic [31:0] live_source_address_out,
    output logic [31:0] live_dest_address_out,
    output logic [$clog2(SETS):0] dst_sets_used_out,
    // completion report to the channel controller
    output logic completion_out,
    output logic [dsa_pkg::CODE_W-1:0] completion_code_out,
    output logic completion_chain_enable_out,
    output logic completion_interrupt_enable_out
);
    localparam int PTR_W = $clog2(SETS);

    // bus handshake state
    dsa_pkg::dsa_bus_t bus_state_reg;
    logic waitrequest_reg;
    logic [31:0] readdata_reg;
    logic [1:0] response_reg;
    // active options and live addresses
    logic [31:0] opts_reg;
    logic [31:0] src_reg;
    logic [31:0] dst_reg;
    // destination fifo register sets
    logic [31:0] set_opts_reg [SETS];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    // completion report
    logic done_reg;
    logic [dsa_pkg::CODE_W-1:0] code_reg;
    logic chain_reg;
    logic int_reg;
    // decoded read answer
    logic [31:0] read_value;
    logic addr_hit;
    // push and pop qualified by room and content
    logic push_ok;
    logic pop_ok;
    // options word popped from the fifo
    logic [31:0] pop_opts;

    // stepping links to the two stepper copies
    dsa_step_if src_step ();
    dsa_step_if dst_step ();

    assign src_step.cur = src_reg;
    assign src_step.bytes = read_bytes_in;
    assign src_step.const_mode = opts_reg[dsa_pkg::SAM_BIT];
    assign src_step.fifo_width_code = opts_reg[dsa_pkg::FIFO_WIDTH_CODE_LSB +: dsa_pkg::FIFO_WIDTH_CODE_W];
    assign dst_step.cur = dst_reg;
    assign dst_step.bytes = write_bytes_in;
    assign dst_step.const_mode = opts_reg[dsa_pkg::DAM_BIT];
    assign dst_step.fifo_width_code = opts_reg[dsa_pkg::FIFO_WIDTH_CODE_LSB +: dsa_pkg::FIFO_WIDTH_CODE_W];

    // source side address arithmetic
    dsa_addr_stepper src_stepper (
        .step (src_step.stepper)
    );

    // destination side address arithmetic
    dsa_addr_stepper dst_stepper (
        .step (dst_step.stepper)
    );

    assign push_ok = dst_push_in && (count_reg < (PTR_W+1)'(SETS));
    assign pop_ok = dst_pop_in && (count_reg != '0);
    assign pop_opts = set_opts_reg[rd_ptr_reg];

    // active options word, loaded only by the controller
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            opts_reg <= dsa_pkg::RESET_OPTS;
        end
        else if (ce_in && tr_load_in)
        begin
            opts_reg <= tr_options_in & dsa_pkg::OPTS_MASK;
        end
    end

    // live source address; a new request outranks a read step
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            src_reg <= dsa_pkg::RESET_ADDR;
        end
        else if (ce_in)
        begin
            if (tr_load_in)
            begin
                src_reg <= tr_src_addr_in;
            end
            else if (read_done_in)
            begin
                src_reg <= src_step.next;
            end
        end
    end

    // live destination address, stepped by completed writes
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            dst_reg <= dsa_pkg::RESET_ADDR;
        end
        else if (ce_in)
        begin
            if (tr_load_in)
            begin
                dst_reg <= tr_dst_addr_in;
            end
            else if (write_done_in)
            begin
                dst_reg <= dst_step.next;
            end
        end
    end

    // destination set storage
    // one register set per fifo entry; a push copies the active options
    for (genvar g = 0; g < SETS; g++)
    begin : g_set
        always_ff @(posedge clock_in or posedge reset_in)
        begin
            if (reset_in)
            begin
                set_opts_reg[g] <= dsa_pkg::RESET_OPTS;
            end
            else if (ce_in && push_ok && (wr_ptr_reg == PTR_W'(g)))
            begin
                set_opts_reg[g] <= opts_reg;
            end
        end
    end

    // fifo pointers and occupancy; a push into a full fifo is dropped
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else if (ce_in)
        begin
            if (push_ok)
            begin
                wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
            end
            if (pop_ok)
            begin
                rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
            end
            if (push_ok && !pop_ok)
            begin
                count_reg <= count_reg + (PTR_W+1)'(1);
            end
            else if (pop_ok && !push_ok)
            begin
                count_reg <= count_reg - (PTR_W+1)'(1);
            end
        end
    end

    // completion report, one pulse per retired set
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            done_reg <= 1'b0;
            code_reg <= '0;
            chain_reg <= 1'b0;
            int_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            done_reg <= pop_ok;
            if (pop_ok)
            begin
                code_reg <= pop_opts[dsa_pkg::CODE_LSB +: dsa_pkg::CODE_W];
                chain_reg <= pop_opts[dsa_pkg::CHAIN_BIT];
                int_reg <= pop_opts[dsa_pkg::INT_BIT];
            end
        end
    end

    // register read decode; unmapped or misaligned addresses miss
    always_comb
    begin
        read_value = '0;
        addr_hit = 1'b1;
        case (avs_address_in)
            dsa_pkg::OFF_OPTS:
            begin
                read_value = opts_reg;
            end
            dsa_pkg::OFF_SRC:
            begin
                read_value = src_reg;
            end
            dsa_pkg::OFF_DST_ADDR:
            begin
                read_value = dst_reg;
            end
            dsa_pkg::OFF_STATUS:
            begin
                read_value = 32'(count_reg);
            end
            default:
            begin
                // sets sit at consecutive words after the base
                if ((avs_address_in >= dsa_pkg::OFF_SET_BASE) &&
                    (avs_address_in < dsa_pkg::OFF_SET_BASE + 8'(4 * SETS)) &&
                    (avs_address_in[1:0] == 2'h0))
                begin
                    read_value = set_opts_reg[PTR_W'((avs_address_in -
                        dsa_pkg::OFF_SET_BASE) >> 2)];
                end
                else
                begin
                    addr_hit = 1'b0;
                end
            end
        endcase
    end

    // avalon handshake: one wait cycle, then the answer for one cycle
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            bus_state_reg <= dsa_pkg::DSA_BUS_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg <= '0;
            response_reg <= dsa_pkg::RESP_OK;
        end
        else if (ce_in)
        begin
            case (bus_state_reg)
                dsa_pkg::DSA_BUS_IDLE:
                begin
                    if (avs_read_in || avs_write_in)
                    begin
                        readdata_reg <= avs_read_in ? read_value : '0;
                        response_reg <= addr_hit ? dsa_pkg::RESP_OK : dsa_pkg::RESP_DECERR;
                        waitrequest_reg <= 1'b0;
                        bus_state_reg <= dsa_pkg::DSA_BUS_ANSWER;
                    end
                end
                dsa_pkg::DSA_BUS_ANSWER:
                begin
                    // master releases at this edge; stall any new request once
                    waitrequest_reg <= 1'b1;
                    bus_state_reg <= dsa_pkg::DSA_BUS_IDLE;
                end
                default:
                begin
                    waitrequest_reg <= 1'b1;
                    bus_state_reg <= dsa_pkg::DSA_BUS_IDLE;
                end
            endcase
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata_out = readdata_reg;
    assign avs_response_out = response_reg;
    assign avs_waitrequest_out = waitrequest_reg;
    assign active_options_out = opts_reg;
    assign live_source_address_out = src_reg;
    assign live_dest_address_out = dst_reg;
    assign dst_sets_used_out = count_reg;
    assign completion_out = done_reg;
    assign completion_code_out = code_reg;
    assign completion_chain_enable_out = chain_reg;
    assign completion_interrupt_enable_out = int_reg;

    // checks on the state that this block drives
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    opts_reserved_zero_a: assert property ((opts_reg & ~dsa_pkg::OPTS_MASK) == '0)
        else $error("reserved option bit set");
    load_only_controller_a: assert property (
        !(ce_in && tr_load_in) |=> opts_reg == $past(opts_reg))
        else $error("options changed without a load");
    write_no_effect_a: assert property (
        ce_in && avs_write_in && !tr_load_in |=> $stable(opts_reg))
        else $error("software write changed options");
    src_increment_a: assert property (
        ce_in && read_done_in && !tr_load_in && !opts_reg[dsa_pkg::SAM_BIT]
        |=> src_reg == $past(src_reg) + 32'($past(read_bytes_in)))
        else $error("source increment wrong");
    src_wrap_window_a: assert property (
        ce_in && read_done_in && !tr_load_in && opts_reg[dsa_pkg::SAM_BIT] &&
        opts_reg[dsa_pkg::FIFO_WIDTH_CODE_LSB +: dsa_pkg::FIFO_WIDTH_CODE_W] == dsa_pkg::FIFO_WIDTH_CODE_MAX
        |=> src_reg[31:5] == $past(src_reg[31:5]))
        else $error("source left its fifo window");
    dst_increment_a: assert property (
        ce_in && write_done_in && !tr_load_in && !opts_reg[dsa_pkg::DAM_BIT]
        |=> dst_reg == $past(dst_reg) + 32'($past(write_bytes_in)))
        else $error("destination increment wrong");
    sets_bounded_a: assert property (count_reg <= (PTR_W+1)'(SETS))
        else $error("destination set count over depth");
    done_code_a: assert property (
        ce_in && pop_ok |=> done_reg && code_reg ==
        $past(pop_opts[dsa_pkg::CODE_LSB +: dsa_pkg::CODE_W]))
        else $error("completion code mismatch");
    bus_answer_a: assert property (
        ce_in && (avs_read_in || avs_write_in) && waitrequest_reg &&
        bus_state_reg == dsa_pkg::DSA_BUS_IDLE |=> !waitrequest_reg ##1 waitrequest_reg)
        else $error("bus answer timing wrong");

    load_seen_c: cover property (ce_in && tr_load_in ##1 ce_in && read_done_in);
    fifo_full_c: cover property (count_reg == (PTR_W+1)'(SETS));
    done_pulse_c: cover property (done_reg && chain_reg);
    read_answer_c: cover property (avs_read_in && !waitrequest_reg);
endmodule // dsa_source_active

// ### design/dsa_pkg.sv
// shared constants for the source-active debug view
package dsa_pkg;
    // data and address widths of the register bus
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    // width of the byte count carried by one read or write step
    localparam int STEP_W = 16;
    // number of destination fifo register sets
    localparam int DST_SETS = 4;
    // byte offsets of the registers
    localparam logic [7:0] OFF_OPTS = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_DST_ADDR = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_SET_BASE = 8'h10;
    // implemented bits of the options word, all others read zero
    localparam logic [31:0] OPTS_MASK = 32'h0053_f773;
    // field positions inside the options word
    localparam int CHAIN_BIT = 22;
    localparam int INT_BIT = 20;
    localparam int CODE_LSB = 12;
    localparam int CODE_W = 6;
    localparam int FIFO_WIDTH_CODE_LSB = 8;
    localparam int FIFO_WIDTH_CODE_W = 3;
    localparam int URG_LSB = 4;
    localparam int URG_W = 3;
    localparam int DAM_BIT = 1;
    localparam int SAM_BIT = 0;
    // largest defined fifo width code (256 bits)
    localparam logic [2:0] FIFO_WIDTH_CODE_MAX = 3'h5;
    // reset values
    localparam logic [31:0] RESET_OPTS = 32'h0000_0000;
    localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
    // avalon response codes
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // register bus handshake states
    typedef enum logic [0:0] {
        DSA_BUS_IDLE = 1'b0,
        DSA_BUS_ANSWER = 1'b1
    } dsa_bus_t;
endpackage

// ### design/dsa_step_if.sv
`timescale 1ns/10ps
// one address stepping request and its result
interface dsa_step_if;
    // present address
    logic [31:0] cur;
    // bytes moved by the step
    logic [dsa_pkg::STEP_W-1:0] bytes;
    // constant addressing mode selected
    logic const_mode;
    // fifo width code
    logic [dsa_pkg::FIFO_WIDTH_CODE_W-1:0] fifo_width_code;
    // stepped address
    logic [31:0] next;
    modport owner (output cur, output bytes, output const_mode, output fifo_width_code, input next);
    modport stepper (input cur, input bytes, input const_mode, input fifo_width_code, output next);
endinterface

// ### design/dsa_addr_stepper.sv
`timescale 1ns/10ps
// combinational address stepper shared by the source and destination side
module dsa_addr_stepper
(
    // step request and result
    dsa_step_if.stepper step
);
    // byte mask of the fifo window
    logic [31:0] win_mask;
    // plain incremented address
    logic [31:0] sum;
    // width code after reserved codes are folded
    logic [dsa_pkg::FIFO_WIDTH_CODE_W-1:0] width_code;

    // next address from mode and width
    always_comb
    begin
        // reserved width codes
        // codes 6 and 7 are undefined; fold them to the narrowest window
        if (step.fifo_width_code > dsa_pkg::FIFO_WIDTH_CODE_MAX)
        begin
            width_code = '0;
        end
        else
        begin
            width_code = step.fifo_width_code;
        end
        // width code decode
        // code n gives a window of 2**n bytes, 8 to 256 bits
        win_mask = (32'h0000_0001 << width_code) - 32'h0000_0001;
        sum = step.cur + 32'(step.bytes);
        if (step.const_mode)
        begin
            // wrap inside the window, upper bits never move
            step.next = (step.cur & ~win_mask) | (sum & win_mask);
        end
        else
        begin
            // plain increment through the array
            step.next = sum;
        end
    end
endmodule // dsa_addr_stepper

// ### bench/dsa_ctrl_model.sv
`timescale 1ns/10ps
// channel controller model: submits transfer requests and progress pulses
module dsa_ctrl_model
(
    // clock
    input wire logic clock_in,
    // transfer request
    output logic tr_load_out,
    output logic [31:0] tr_options_out,
    output logic [31:0] tr_src_addr_out,
    output logic [31:0] tr_dst_addr_out,
    // progress and fifo pulses
    output logic read_done_out,
    output logic write_done_out,
    output logic [15:0] step_bytes_out,
    output logic dst_push_out,
    output logic dst_pop_out
);
    // quiet outputs from time zero
    initial
    begin
        {tr_load_out, read_done_out, write_done_out, dst_push_out, dst_pop_out} = 5'h00;
        {tr_options_out, tr_src_addr_out, tr_dst_addr_out} = 96'h0;
        step_bytes_out = 16'h0000;
    end

    task automatic load(input logic [31:0] o, input logic [31:0] s, input logic [31:0] d);
        @(posedge clock_in);
        tr_load_out <= 1'b1;
        tr_options_out <= o;
        tr_src_addr_out <= s;
        tr_dst_addr_out <= d;
        @(posedge clock_in);
        tr_load_out <= 1'b0;
        // released data turns to junk so a stale copy cannot pass for a load
        tr_options_out <= ~o;
        tr_src_addr_out <= ~s;
        tr_dst_addr_out <= ~d;
    endtask

    // one pulse: kind 0 read, 1 write, 2 push, 3 pop
    task automatic pulse(input int kind, input logic [15:0] b);
        @(posedge clock_in);
        step_bytes_out <= b;
        read_done_out <= (kind == 0);
        write_done_out <= (kind == 1);
        dst_push_out <= (kind == 2);
        dst_pop_out <= (kind == 3);
        @(posedge clock_in);
        {read_done_out, write_done_out, dst_push_out, dst_pop_out} <= 4'h0;
        step_bytes_out <= ~b;
    endtask
endmodule // dsa_ctrl_model

// ### bench/test_dsa_source_active.sv
`timescale 1ns/10ps
// compare, count, and report a difference at once
`define CHECK(got, exp, what) \
    begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t: %s", $time, what); end end
module test_dsa_source_active;
    // clock, reset, enable and bus drive
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [7:0] address = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    // controller model wires
    logic tr_load, read_done, write_done, push, pop;
    logic [31:0] tr_opts, tr_src, tr_dst;
    logic [15:0] step_bytes;
    // design outputs
    logic [31:0] readdata, opts_q, src_q, dst_q;
    logic [1:0] resp;
    logic waitreq, done, chain, inten;
    logic [2:0] used;
    logic [5:0] code;
    // bookkeeping
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;

    // 50 MHz clock
    always #10 clock = ~clock;

    dsa_ctrl_model ctrl (.clock_in(clock), .tr_load_out(tr_load), .tr_options_out(tr_opts),
        .tr_src_addr_out(tr_src), .tr_dst_addr_out(tr_dst), .read_done_out(read_done),
        .write_done_out(write_done), .step_bytes_out(step_bytes), .dst_push_out(push),
        .dst_pop_out(pop));

    dsa_source_active uut (.clock_in(clock), .reset_in(reset), .ce_in(ce),
        .avs_address_in(address), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(readdata),
        .avs_response_out(resp), .avs_waitrequest_out(waitreq), .tr_load_in(tr_load),
        .tr_options_in(tr_opts), .tr_src_addr_in(tr_src), .tr_dst_addr_in(tr_dst),
        .read_done_in(read_done), .read_bytes_in(step_bytes), .write_done_in(write_done),
        .write_bytes_in(step_bytes), .dst_push_in(push), .dst_pop_in(pop),
        .active_options_out(opts_q), .live_source_address_out(src_q),
        .live_dest_address_out(dst_q), .dst_sets_used_out(used), .completion_out(done),
        .completion_code_out(code), .completion_chain_enable_out(chain),
        .completion_interrupt_enable_out(inten));

    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            summarize();
        end
    end

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        address <= a;
        wdata <= wd;
        rd_en <= !wr;
        wr_en <= wr;
        // wait as long as the answer takes; only the hang guard ends a stuck wait
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitreq !== 1'b0);
        d = readdata;
        r = resp;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        // one wait state: the answer is sampled at the second edge
        `CHECK(n, 2, "bus answer latency")
        // let an edge pass so a following request never reassigns the strobes in this step
        @(posedge clock);
    endtask

    // read and compare data and response
    task automatic expect_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        bus(1'b0, a, 32'h0, d, r);
        `CHECK(d, e, "read data")
        `CHECK(r, er, "read response")
    endtask

    // reset values of the view
    task automatic t_reset();
        expect_read(8'h00, 32'h0, 2'h0);
        expect_read(8'h04, 32'h0, 2'h0);
    endtask

    // every field alone, then only reserved bits; software writes ignored
    task automatic t_fields();
        logic [31:0] d;
        logic [1:0] r;
        logic [31:0] tbl [8] = '{32'h0040_0000, 32'h0010_0000, 32'h0003_f000, 32'h0000_0700,
                                 32'h0000_0070, 32'h0000_0002, 32'h0000_0001, 32'hffac_088c};
        for (int i = 0; i < 8; i++)
        begin
            ctrl.load(tbl[i], 32'h0, 32'h0);
            @(posedge clock);
            `CHECK(opts_q, tbl[i] & 32'h0053_f773, "options mirror")
            expect_read(8'h00, tbl[i] & 32'h0053_f773, 2'h0);
        end
        bus(1'b1, 8'h00, 32'hffff_ffff, d, r);
        bus(1'b1, 8'h04, 32'hffff_ffff, d, r);
        expect_read(8'h00, 32'h0, 2'h0);
        expect_read(8'h04, 32'h0, 2'h0);
    endtask

    // increment mode ignores the width field and rolls over 32 bits
    task automatic t_src_step();
        ctrl.load(32'h0000_0200, 32'h0000_1000, 32'h0);
        ctrl.pulse(0, 16'h0004);
        ctrl.pulse(0, 16'h0010);
        @(posedge clock);
        `CHECK(src_q, 32'h0000_1014, "source increment")
        ctrl.load(32'h0, 32'hffff_fffe, 32'h0);
        ctrl.pulse(0, 16'h0004);
        expect_read(8'h04, 32'h0000_0002, 2'h0);
    endtask

    // constant mode wraps in a window set by every width code
    task automatic t_wrap();
        int win;
        for (int f = 0; f < 8; f++)
        begin
            // reserved codes 6 and 7 behave as the 8-bit width
            win = (f < 6) ? (1 << f) : 1;
            ctrl.load(32'h0000_0001 | (f << 8), 32'h0000_0440, 32'h0);
            for (int i = 1; i <= win; i++)
            begin
                ctrl.pulse(0, 16'h0001);
                @(posedge clock);
                `CHECK(src_q, 32'h0000_0440 + (i % win), "source wrap")
            end
        end
    endtask

    // destination side wraps in constant mode and increments otherwise
    task automatic t_dst_step();
        ctrl.load(32'h0000_0102, 32'h0, 32'h0000_0300);
        ctrl.pulse(1, 16'h0001);
        @(posedge clock);
        `CHECK(dst_q, 32'h0000_0301, "dest step")
        ctrl.pulse(1, 16'h0001);
        expect_read(8'h08, 32'h0000_0300, 2'h0);
        ctrl.load(32'h0000_0100, 32'h0, 32'h0000_0300);
        ctrl.pulse(1, 16'h0003);
        @(posedge clock);
        `CHECK(dst_q, 32'h0000_0303, "dest increment")
    endtask

    // fill four sets, refuse a fifth, retire in order with completion reports
    task automatic t_sets();
        for (int k = 0; k < 5; k++)
        begin
            ctrl.load(((k + 1) << 12) | ((k % 2) ? 32'h0040_0000 : 32'h0010_0000), 32'h0, 32'h0);
            ctrl.pulse(2, 16'h0000);
        end
        @(posedge clock);
        `CHECK(used, 3'h4, "sets used")
        expect_read(8'h0c, 32'h4, 2'h0);
        for (int k = 0; k < 4; k++)
        begin
            expect_read(8'h10 + 8'(4 * k), ((k + 1) << 12) | ((k % 2) ? 32'h0040_0000 : 32'h0010_0000),
                        2'h0);
        end
        for (int k = 0; k < 5; k++)
        begin
            ctrl.pulse(3, 16'h0000);
            @(posedge clock);
            `CHECK(done, (k < 4), "completion pulse")
            if (k < 4)
            begin
                `CHECK(code, 6'(k + 1), "completion code")
                `CHECK({chain, inten}, (k % 2) ? 2'h2 : 2'h1, "completion enables")
            end
            @(posedge clock);
            `CHECK(done, 1'b0, "pulse one cycle")
        end
        `CHECK(used, 3'h0, "sets empty")
    endtask

    // unmapped and misaligned addresses
    task automatic t_map();
        expect_read(8'h20, 32'h0, 2'h3);
        expect_read(8'h02, 32'h0, 2'h3);
    endtask

    // clock enable low holds the live address
    task automatic t_freeze();
        ctrl.load(32'h0, 32'h0000_0080, 32'h0);
        ce <= 1'b0;
        ctrl.pulse(0, 16'h0004);
        @(posedge clock);
        `CHECK(src_q, 32'h0000_0080, "frozen source")
        ce <= 1'b1;
        @(posedge clock);
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        t_reset();
        t_fields();
        t_src_step();
        t_wrap();
        t_dst_step();
        t_sets();
        t_map();
        t_freeze();
        summarize();
    end
endmodule // test_dsa_source_active
